// [design/focus_offset_auto_adjust.sv]
// Focus offset auto-adjust controller with AXI4-Lite register access
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none

module focus_offset_auto_adjust #(
   parameter int unsigned TRACK_HOLD_CYCLES = focus_adjust_pkg::TRACK_HOLD_CYCLES,
   parameter int unsigned DONE_PULSE_CYCLES = focus_adjust_pkg::DONE_PULSE_CYCLES
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write channels
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read channels
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Offset switch drive
   output logic             offset_select_lsb,
   output logic             offset_select_mid,
   output logic             offset_select_msb,
   output logic             offset_inhibit,
   // Error and frame inputs
   input  wire logic        block_error_flag,
   input  wire logic        corrected_frame_pulse,
   input  wire logic        track_jump_hold,
   // Start/stop handshake line (two-way)
   input  wire logic        handshake_in,
   output logic             handshake_out,
   output logic             handshake_oe,
   // Interrupt
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Level ordering helpers
   function automatic logic [2:0] level_down(input logic [2:0] l);
      return 3'(l - 3'h1);
   endfunction
   function automatic logic [2:0] level_up(input logic [2:0] l);
      return 3'(l + focus_adjust_pkg::BACKOFF_STEPS);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State
   focus_adjust_pkg::adj_state_e           state;
   logic [2:0]                             level, saved_level, window_cnt;
   logic [11:0]                            err_count, last_count, err_now;
   logic [10:0]                            edge_count;
   logic [focus_adjust_pkg::TIMER_W-1:0]   hold_timer, done_timer;
   logic [focus_adjust_pkg::CTRL_W-1:0]    ctrl;
   logic [focus_adjust_pkg::IRQ_W-1:0]     irq_status, irq_enable, next_irq_status;
   logic [focus_adjust_pkg::IRQ_W-1:0]     irq_clear, irq_events;
   logic [31:0]                            rd_word;
   logic                                   frame_prev, jump_prev, armed;
   logic                                   frame_rise, jump_rise, paused, count_ok, window_end;
   logic                                   exceed, start, abort, finish;
   logic                                   wr_fire, rd_mapped, wr_mapped;

   assign level = {offset_select_msb, offset_select_mid, offset_select_lsb};

   ////////////////////////////////////////////////////////////////////////////
   // Measurement qualifiers
   always_comb begin
      frame_rise = corrected_frame_pulse && !frame_prev;
      jump_rise  = track_jump_hold && !jump_prev;
      paused     = jump_rise || (hold_timer != '0);
      count_ok   = (state == focus_adjust_pkg::ST_MEASURE) && frame_rise && !paused;
      err_now    = 12'(err_count + {11'h000, count_ok && block_error_flag});
      window_end = count_ok && (edge_count == 11'(focus_adjust_pkg::WINDOW_EDGES - 11'h001));
      exceed     = err_now > focus_adjust_pkg::ERROR_THRESHOLD;
      start      = (state == focus_adjust_pkg::ST_IDLE) && armed && handshake_in
                   && ctrl[focus_adjust_pkg::CTRL_ENABLE_BIT];
      abort      = (state == focus_adjust_pkg::ST_MEASURE) && !handshake_in;
      finish     = !abort && window_end
                   && (exceed || window_cnt == focus_adjust_pkg::LAST_WINDOW);
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_prev <= 1'b0;
         jump_prev  <= 1'b0;
         hold_timer <= '0;
      end else begin
         frame_prev <= corrected_frame_pulse;
         jump_prev  <= track_jump_hold;
         if (jump_rise) begin
            hold_timer <= focus_adjust_pkg::TIMER_W'(TRACK_HOLD_CYCLES - 1);
         end else if (hold_timer != '0) begin
            hold_timer <= hold_timer - 1'b1;
         end
      end
   end
   // A start needs the line seen low first, so a controller still holding it
   // high after the done pulse does not retrigger at once.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         armed <= 1'b0;
      end else if (start) begin
         armed <= 1'b0;
      end else if (!handshake_in && state != focus_adjust_pkg::ST_DONE) begin
         armed <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Adjustment sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= focus_adjust_pkg::ST_IDLE;
         {offset_select_msb, offset_select_mid, offset_select_lsb} <= focus_adjust_pkg::START_LEVEL;
         saved_level   <= focus_adjust_pkg::START_LEVEL;
         err_count     <= '0;
         last_count    <= '0;
         edge_count    <= '0;
         window_cnt    <= '0;
         done_timer    <= '0;
         handshake_oe  <= 1'b0;
         handshake_out <= 1'b0;
      end else begin
         handshake_out <= 1'b0;
         case (state)
            focus_adjust_pkg::ST_IDLE: begin
               if (start) begin
                  saved_level <= level;
                  {offset_select_msb, offset_select_mid, offset_select_lsb} <=
                     focus_adjust_pkg::START_LEVEL;
                  err_count   <= '0;
                  edge_count  <= '0;
                  window_cnt  <= '0;
                  state       <= focus_adjust_pkg::ST_MEASURE;
               end
            end
            focus_adjust_pkg::ST_MEASURE: begin
               if (abort) begin
                  {offset_select_msb, offset_select_mid, offset_select_lsb} <= saved_level;
                  state <= focus_adjust_pkg::ST_IDLE;
               end else if (window_end) begin
                  err_count  <= '0;
                  edge_count <= '0;
                  last_count <= err_now;
                  window_cnt <= window_cnt + 3'h1;
                  if (exceed) begin
                     {offset_select_msb, offset_select_mid, offset_select_lsb} <=
                        level_up(level);
                  end else begin
                     // Wrapping back to the start level after all eight ends the run
                     {offset_select_msb, offset_select_mid, offset_select_lsb} <=
                        level_down(level);
                  end
                  if (finish) begin
                     done_timer   <= focus_adjust_pkg::TIMER_W'(DONE_PULSE_CYCLES - 1);
                     handshake_oe <= 1'b1;
                     state        <= focus_adjust_pkg::ST_DONE;
                  end
               end else if (count_ok) begin
                  err_count  <= err_now;
                  edge_count <= edge_count + 11'h001;
               end
            end
            focus_adjust_pkg::ST_DONE: begin
               if (done_timer == '0) begin
                  handshake_oe <= 1'b0;
                  state        <= focus_adjust_pkg::ST_IDLE;
               end else begin
                  done_timer <= done_timer - 1'b1;
               end
            end
            default: begin
               handshake_oe <= 1'b0;
               state        <= focus_adjust_pkg::ST_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         offset_inhibit <= 1'b0;
      end else begin
         offset_inhibit <= ctrl[focus_adjust_pkg::CTRL_FORCE_INH_BIT] && !start
                           && (state != focus_adjust_pkg::ST_MEASURE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: a new event wins over a clear in the same cycle
   always_comb begin
      irq_events = '0;
      irq_events[focus_adjust_pkg::IRQ_DONE_BIT]   = finish;
      irq_events[focus_adjust_pkg::IRQ_ABORT_BIT]  = abort;
      irq_events[focus_adjust_pkg::IRQ_WINDOW_BIT] = window_end && !abort;
      irq_clear = (wr_fire && awaddr == focus_adjust_pkg::ADDR_IRQ_CLEAR && wstrb[0])
                  ? wdata[focus_adjust_pkg::IRQ_W-1:0] : '0;
      next_irq_status = (irq_status & ~irq_clear) | irq_events;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= '0;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq        <= |(next_irq_status & irq_enable);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave: address and data are taken together, one cycle after
   // both are valid; simpler than separate buffering, still legal for masters
   assign wr_fire = awready && awvalid && wvalid;
   always_comb begin
      wr_mapped = (awaddr == focus_adjust_pkg::ADDR_CTRL)
               || (awaddr == focus_adjust_pkg::ADDR_IRQ_ENABLE)
               || (awaddr == focus_adjust_pkg::ADDR_IRQ_CLEAR);
      rd_mapped = 1'b1;
      rd_word   = 32'h00000000;
      case (araddr)
         focus_adjust_pkg::ADDR_CTRL:       rd_word = {30'h00000000, ctrl};
         focus_adjust_pkg::ADDR_STATUS:     rd_word = {24'h000000, armed, handshake_in,
                                               state, offset_inhibit, level};
         focus_adjust_pkg::ADDR_COUNT:      rd_word = {20'h00000, last_count};
         focus_adjust_pkg::ADDR_IRQ_STATUS: rd_word = {29'h00000000, irq_status};
         focus_adjust_pkg::ADDR_IRQ_ENABLE: rd_word = {29'h00000000, irq_enable};
         focus_adjust_pkg::ADDR_IRQ_CLEAR:  rd_word = 32'h00000000;
         default:                           rd_mapped = 1'b0;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= focus_adjust_pkg::RESP_OKAY;
      end else begin
         awready <= !awready && !bvalid && awvalid && wvalid;
         wready  <= !awready && !bvalid && awvalid && wvalid;
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_mapped ? focus_adjust_pkg::RESP_OKAY : focus_adjust_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl       <= focus_adjust_pkg::CTRL_RESET;
         irq_enable <= focus_adjust_pkg::IRQ_ENABLE_RESET;
      end else if (wr_fire && wstrb[0]) begin
         if (awaddr == focus_adjust_pkg::ADDR_CTRL) begin
            ctrl <= wdata[focus_adjust_pkg::CTRL_W-1:0];
         end
         if (awaddr == focus_adjust_pkg::ADDR_IRQ_ENABLE) begin
            irq_enable <= wdata[focus_adjust_pkg::IRQ_W-1:0];
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= focus_adjust_pkg::RESP_OKAY;
      end else begin
         arready <= !arready && !rvalid && arvalid;
         if (arready && arvalid) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_mapped ? focus_adjust_pkg::RESP_OKAY : focus_adjust_pkg::RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_start_level_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      start |=> (level == 3'h0) && !offset_inhibit && (state == focus_adjust_pkg::ST_MEASURE))
      else $error("adjustment did not start at level 0");
   a_step_down_one: assert property (@(posedge aclk) disable iff (!aresetn)
      (window_end && !abort && !exceed) |=> level == level_down($past(level)))
      else $error("level did not step one down after a quiet window");
   a_wrap_seven: assert property (@(posedge aclk) disable iff (!aresetn)
      (window_end && !abort && !exceed && level == 3'h0) |=> level == 3'h7)
      else $error("level 0 did not step down to level 7");
   a_back_off_three: assert property (@(posedge aclk) disable iff (!aresetn)
      (window_end && !abort && exceed) |=> (level == 3'($past(level) + 3'h3))
      && (state == focus_adjust_pkg::ST_DONE))
      else $error("level did not back off three after threshold");
   a_hold_final: assert property (@(posedge aclk) disable iff (!aresetn)
      (state != focus_adjust_pkg::ST_MEASURE && !start) |=> $stable(level))
      else $error("level changed outside an adjustment");
   a_count_edge: assert property (@(posedge aclk) disable iff (!aresetn)
      (count_ok && !window_end && !abort && $rose(corrected_frame_pulse))
      |=> err_count == 12'($past(err_count) + {11'h000, $past(block_error_flag)}))
      else $error("error count missed a sampled block error");
   a_pause_jump: assert property (@(posedge aclk) disable iff (!aresetn)
      jump_rise |=> (hold_timer != '0 || TRACK_HOLD_CYCLES == 1) && $stable(err_count))
      else $error("track jump did not suspend counting");
   a_abort_restore: assert property (@(posedge aclk) disable iff (!aresetn)
      abort |=> (level == saved_level) && (state == focus_adjust_pkg::ST_IDLE))
      else $error("abort did not restore the earlier level");
   a_done_low: assert property (@(posedge aclk) disable iff (!aresetn)
      finish |=> handshake_oe && !handshake_out ##1 handshake_oe && !handshake_out)
      else $error("completion did not drive the line low");
   a_release_line: assert property (@(posedge aclk) disable iff (!aresetn)
      (state == focus_adjust_pkg::ST_DONE && done_timer == '0) |=> !handshake_oe)
      else $error("line not released after completion pulse");

endmodule

`default_nettype wire

// [design/focus_adjust_pkg.sv]
// Constants shared by the focus offset auto-adjust controller
package focus_adjust_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses, one 32-bit word each)
   localparam logic [7:0] ADDR_CTRL       = 8'h00;
   localparam logic [7:0] ADDR_STATUS     = 8'h04;
   localparam logic [7:0] ADDR_COUNT      = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
   localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h14;

   localparam int         CTRL_ENABLE_BIT    = 0;
   localparam int         CTRL_FORCE_INH_BIT = 1;
   localparam int         CTRL_W             = 2;
   localparam logic [1:0] CTRL_RESET         = 2'h1;

   localparam int         IRQ_DONE_BIT   = 0;
   localparam int         IRQ_ABORT_BIT  = 1;
   localparam int         IRQ_WINDOW_BIT = 2;
   localparam int         IRQ_W          = 3;
   localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Adjustment algorithm
   localparam logic [2:0]  START_LEVEL     = 3'h0;
   localparam logic [2:0]  BACKOFF_STEPS   = 3'h3;
   localparam logic [2:0]  LAST_WINDOW     = 3'h7;
   localparam logic [11:0] ERROR_THRESHOLD = 12'h7D0;
   localparam int          FRAMES_PER_STEP  = 256;
   localparam int          STEPS_PER_WINDOW = 6;
   localparam logic [10:0] WINDOW_EDGES = 11'(FRAMES_PER_STEP * STEPS_PER_WINDOW);

   ////////////////////////////////////////////////////////////////////////////
   // Timing at the 200 MHz system clock
   localparam int CLK_FREQ_KHZ      = 200000;
   localparam int TRACK_HOLD_US     = 1200;
   localparam int DONE_PULSE_US     = 3400;
   localparam int TRACK_HOLD_CYCLES = TRACK_HOLD_US * CLK_FREQ_KHZ / 1000;
   localparam int DONE_PULSE_CYCLES = DONE_PULSE_US * CLK_FREQ_KHZ / 1000;
   localparam int TIMER_W           = 20;

   typedef enum logic [1:0] {ST_IDLE, ST_MEASURE, ST_DONE} adj_state_e;

endpackage

// [sim/focus_far_side.sv]
// Behavioural model of the system controller and the error decoder
`timescale 1ns/10ps
`default_nettype none
module focus_far_side (
   // Clock
   input  wire logic aclk,
   // Decoder outputs
   output logic      block_error_flag,
   output logic      corrected_frame_pulse,
   output logic      track_jump_hold,
   // Handshake line
   output logic      handshake_in,
   input  wire logic handshake_out,
   input  wire logic handshake_oe
);
   logic ctrl_level;
   // Device pull-down wins over the controller while it drives the line
   always_comb handshake_in = handshake_oe ? handshake_out : ctrl_level;
   initial begin
      block_error_flag = 1'b0;
      corrected_frame_pulse = 1'b0;
      track_jump_hold = 1'b0;
      ctrl_level = 1'b0;
   end
   // Frames are compressed to two clocks each to keep runs short
   task automatic frames(input int n, input logic err);
      repeat (n) begin
         @(posedge aclk);
         corrected_frame_pulse <= 1'b1;
         block_error_flag <= err;
         @(posedge aclk);
         corrected_frame_pulse <= 1'b0;
      end
   endtask
   task automatic jump();
      @(posedge aclk);
      track_jump_hold <= 1'b1;
      @(posedge aclk);
      track_jump_hold <= 1'b0;
   endtask
   task automatic drive_line(input logic v);
      @(posedge aclk);
      ctrl_level <= v;
   endtask
endmodule
`default_nettype wire

// [sim/focus_offset_auto_adjust_test.sv]
// Self-checking bench for the focus offset auto-adjust controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR %0t: got %0h expected %0h", $time, g, e); end end
module focus_offset_auto_adjust_test;
   localparam int unsigned HOLD  = 20;
   localparam int unsigned PULSE = 30;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic        sel_lsb, sel_mid, sel_msb, offset_inhibit;
   logic        block_error_flag, corrected_frame_pulse, track_jump_hold;
   logic        handshake_in, handshake_out, handshake_oe;
   logic [2:0]  level;
   int          n_mismatch, compares, i, k, oe_cycles;
   assign level = {sel_msb, sel_mid, sel_lsb};

   focus_offset_auto_adjust #(.TRACK_HOLD_CYCLES(HOLD), .DONE_PULSE_CYCLES(PULSE)) dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .offset_select_lsb(sel_lsb), .offset_select_mid(sel_mid), .offset_select_msb(sel_msb),
      .offset_inhibit(offset_inhibit), .block_error_flag(block_error_flag),
      .corrected_frame_pulse(corrected_frame_pulse), .track_jump_hold(track_jump_hold),
      .handshake_in(handshake_in), .handshake_out(handshake_out),
      .handshake_oe(handshake_oe), .irq(irq));
   focus_far_side far (
      .aclk(aclk), .block_error_flag(block_error_flag),
      .corrected_frame_pulse(corrected_frame_pulse), .track_jump_hold(track_jump_hold),
      .handshake_in(handshake_in), .handshake_out(handshake_out),
      .handshake_oe(handshake_oe));

   always #2.5 aclk = ~aclk;
   always @(posedge aclk) if (handshake_oe === 1'b1) oe_cycles++;

   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      `CHK(bresp, er)
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      `CHK(rdata, e)
      `CHK(rresp, er)
      rready <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(focus_adjust_pkg::ADDR_CTRL, 32'h0000_0001, focus_adjust_pkg::RESP_OKAY);
      rd(focus_adjust_pkg::ADDR_IRQ_ENABLE, 32'h0000_0000, focus_adjust_pkg::RESP_OKAY);
      rd(8'h18, 32'h0000_0000, focus_adjust_pkg::RESP_SLVERR);
      wr(8'h18, 32'h0000_0001, focus_adjust_pkg::RESP_SLVERR);
      wr(focus_adjust_pkg::ADDR_IRQ_ENABLE, 32'h0000_0001, focus_adjust_pkg::RESP_OKAY);
      far.drive_line(1'b1);
      repeat (3) @(posedge aclk);
      `CHK({offset_inhibit, level}, 4'h0)
      // Each window gets a distinct error count, never past the threshold
      for (i = 0; i < 8; i++) begin
         if (i == 0) begin
            far.frames(10, 1'b1);
            far.jump();
            far.frames(5, 1'b1);
            repeat (HOLD) @(posedge aclk);
            far.frames(1525, 1'b0);
            k = 10;
         end else begin
            k = 200 * i + 5;
            far.frames(k, 1'b1);
            far.frames(1535 - k, 1'b0);
         end
         // One frame short of the window the level must not have moved yet
         repeat (3) @(posedge aclk);
         `CHK(level, 3'(8 - i))
         far.frames(1, 1'b0);
         repeat (3) @(posedge aclk);
         `CHK(level, 3'(7 - i))
         if (i == 7) `CHK({handshake_in, irq}, 2'b01)
         rd(focus_adjust_pkg::ADDR_COUNT, 32'(k), focus_adjust_pkg::RESP_OKAY);
      end
      k = 0;
      while (handshake_oe !== 1'b0 && k < 1000) begin
         @(posedge aclk);
         k++;
      end
      `CHK(handshake_oe, 1'b0)
      repeat (2) @(posedge aclk);
      `CHK(oe_cycles, PULSE)
      `CHK(handshake_in, 1'b1)
      far.frames(20, 1'b1);
      `CHK(level, 3'h0)
      rd(focus_adjust_pkg::ADDR_COUNT, 32'd1405, focus_adjust_pkg::RESP_OKAY);
      rd(focus_adjust_pkg::ADDR_IRQ_STATUS, 32'h0000_0005, focus_adjust_pkg::RESP_OKAY);
      wr(focus_adjust_pkg::ADDR_IRQ_CLEAR, 32'h0000_0007, focus_adjust_pkg::RESP_OKAY);
      rd(focus_adjust_pkg::ADDR_IRQ_STATUS, 32'h0000_0000, focus_adjust_pkg::RESP_OKAY);
      `CHK(irq, 1'b0)
      // Abort after one window: the pre-start level must come back
      far.drive_line(1'b0);
      far.drive_line(1'b1);
      repeat (3) @(posedge aclk);
      far.frames(1536, 1'b0);
      repeat (3) @(posedge aclk);
      `CHK(level, 3'h7)
      far.drive_line(1'b0);
      repeat (2) @(posedge aclk);
      `CHK(level, 3'h0)
      rd(focus_adjust_pkg::ADDR_IRQ_STATUS, 32'h0000_0006, focus_adjust_pkg::RESP_OKAY);
      `CHK(irq, 1'b0)
      wr(focus_adjust_pkg::ADDR_IRQ_ENABLE, 32'h0000_0002, focus_adjust_pkg::RESP_OKAY);
      repeat (2) @(posedge aclk);
      `CHK(irq, 1'b1)
      wr(focus_adjust_pkg::ADDR_CTRL, 32'h0000_0003, focus_adjust_pkg::RESP_OKAY);
      repeat (2) @(posedge aclk);
      `CHK(offset_inhibit, 1'b1)
      tally_and_finish();
   end

   // Full run is about 28k cycles; well past that means a hang
   initial begin
      repeat (80000) @(posedge aclk);
      n_mismatch++;
      tally_and_finish();
   end
endmodule
`undef CHK
`default_nettype wire
